//--- design/fdc_regs.sv
// Control and interrupt registers of the FM data demodulator.
// Notes on behaviour
// - Write-only mode register: bit4 subchannel, bit0 main; reset 0 and 1.
// - Both set gives timing extraction; 0/1 main mode; 1/0 subchannel mode.
// - Both clear isolates synchronization until another mode is chosen.
// - Main mode takes whole frames; subchannel mode takes packet groups.
// - Format field 00 A0, 01 A1, 10 B, 11 C; resets to 10.
// - Page mode stores first-corrected packets; no sync or later corrections.
// - Restart bit sends following packets to packet address zero again.
// - Page value 4,5,6,7 gives area 0-31,0-63,0-127,0-271.
// - Soft clear holds sync, correction, descrambler, memory control, main-path interrupts.
// - Soft clear keeps parameter registers, sync counter and read pointer.
// - Host writes soft clear back to 0; reception resumes with settings.
// - Soft clear does not erase memory; new data overwrites old.
// - An event sets its flag; with its mask bit set it drives interrupt output low.
// - Flags: 7 sub pkt, 6 sub tmr, 5 main tmr, 4 frame, 2 sync, 1 main pkt.
// - Write-only mask matches flag bits; 1 enables; resets to 0.
// - Live-packet bit raises no interrupt; clears with bit 1 write.
// Assumes the host bus strobes are already synchronous one-cycle pulses.
`timescale 1ns/1ns
module fdc_regs
(
	input  wire logic       SYS_CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic       CE_I,
	input  wire logic [5:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	output logic      [7:0] RDATA_O,
	input  wire logic [7:0] EVENT_I,
	input  wire logic       LIVE_PKT_I,
	input  wire logic       PKT_STORE_I,
	output logic            INT_N_O,
	output logic      [3:0] MODE_O,
	output logic      [3:0] FMT_O,
	output logic            PAGE_EN_O,
	output logic      [8:0] PKT_ADDR_O,
	output logic      [8:0] PAGE_LAST_O,
	output logic            MAIN_RESET_O,
	output logic            SYNC_ISOLATE_O,
	output logic            PARITY_ERC2_O
);
	typedef struct packed {
		logic       sub_en;
		logic       main_en;
		logic [1:0] fmt;
		logic [6:0] page;
		logic [7:0] mask;
		logic [7:0] flags;
		logic [7:0] rdata;
		logic       int_n;
		logic [3:0] mode;
		logic [3:0] fmt_oh;
		logic [8:0] pkt_addr;
		logic [8:0] page_last;
		logic       iso;
	} fdc_state_t;

	fdc_state_t st_ff;
	fdc_state_t nxt_st;

	// Mode decode from the two enable bits
	function automatic logic [3:0] mode_of(input logic s, input logic m);
		logic [3:0] r;
		r = fdc_pkg::MODE_OFF;
		unique case ({s, m})
			2'b11: r = fdc_pkg::MODE_TIMING;
			2'b01: r = fdc_pkg::MODE_MAIN;
			2'b10: r = fdc_pkg::MODE_SUB;
			2'b00: r = fdc_pkg::MODE_OFF;
		endcase
		return r;
	endfunction

	// Last packet of the accumulation area for the size field
	function automatic logic [8:0] last_of(input logic [1:0] sz);
		logic [8:0] r;
		r = 9'h01f;
		unique case (sz)
			2'b00: r = 9'h01f;
			2'b01: r = 9'h03f;
			2'b10: r = 9'h07f;
			2'b11: r = fdc_pkg::PKT_TOP - 9'h001;
		endcase
		return r;
	endfunction

	logic       wr_flags;
	logic       soft_clr;
	logic [7:0] ev_live;
	logic [7:0] clr_bits;

	// Next-state logic
	always_comb
	begin
		nxt_st   = st_ff;
		wr_flags = WR_I && (ADDR_I == fdc_pkg::ADDR_INT_FLAGS);
		soft_clr = st_ff.page[fdc_pkg::BIT_SOFT_CLEAR];
		// Events of the main path are held off during soft clear
		ev_live  = EVENT_I & fdc_pkg::INT_EVENT_MASK;
		if (soft_clr)
			ev_live = ev_live & ~fdc_pkg::MAIN_PATH_EVENTS;
		clr_bits = wr_flags ? (WDATA_I & fdc_pkg::INT_EVENT_MASK) : 8'h00;
		if (wr_flags && WDATA_I[fdc_pkg::BIT_MAIN_PKT])
			clr_bits[fdc_pkg::BIT_LIVE_PKT] = 1'b1;
		// Set wins over clear
		nxt_st.flags = (st_ff.flags & ~clr_bits) | ev_live;
		if (ev_live[fdc_pkg::BIT_MAIN_PKT])
			nxt_st.flags[fdc_pkg::BIT_LIVE_PKT] = LIVE_PKT_I;
		if (soft_clr)
			nxt_st.flags = nxt_st.flags & ~fdc_pkg::MAIN_PATH_EVENTS;
		// Register writes; parameters survive soft clear
		if (WR_I)
		begin
			unique case (ADDR_I)
				fdc_pkg::ADDR_CHAN_MODE:
				begin
					nxt_st.sub_en  = WDATA_I[fdc_pkg::BIT_SUB_EN];
					nxt_st.main_en = WDATA_I[fdc_pkg::BIT_MAIN_EN];
				end
				fdc_pkg::ADDR_FRAME_FMT: nxt_st.fmt = WDATA_I[1:0];
				fdc_pkg::ADDR_PAGE_CTRL: nxt_st.page = {WDATA_I[fdc_pkg::BIT_SOFT_CLEAR], 1'b0, WDATA_I[4:0]};
				fdc_pkg::ADDR_INT_MASK: nxt_st.mask = WDATA_I & fdc_pkg::INT_EVENT_MASK;
				default: ;
			endcase
		end
		// Page write pointer: stores packets, wraps in area, restarts at zero
		nxt_st.page_last = last_of(st_ff.page[1:0]);
		if (st_ff.page[fdc_pkg::BIT_PAGE_RESTART] || soft_clr)
			nxt_st.pkt_addr = 9'h000;
		else if (st_ff.page[fdc_pkg::BIT_PAGE_EN] && PKT_STORE_I)
			nxt_st.pkt_addr = (st_ff.pkt_addr >= st_ff.page_last) ? 9'h000 : st_ff.pkt_addr + 9'h001;
		if (WR_I && ADDR_I == fdc_pkg::ADDR_PAGE_CTRL && WDATA_I[fdc_pkg::BIT_PAGE_RESTART])
			nxt_st.page[fdc_pkg::BIT_PAGE_RESTART] = 1'b1;
		else if (st_ff.page[fdc_pkg::BIT_PAGE_RESTART])
			nxt_st.page[fdc_pkg::BIT_PAGE_RESTART] = 1'b0;
		// Decoded outputs
		nxt_st.mode = mode_of(nxt_st.sub_en, nxt_st.main_en);
		nxt_st.iso  = (nxt_st.mode == fdc_pkg::MODE_OFF);
		unique case (nxt_st.fmt)
			2'b00: nxt_st.fmt_oh = fdc_pkg::FMT_A0;
			2'b01: nxt_st.fmt_oh = fdc_pkg::FMT_A1;
			2'b10: nxt_st.fmt_oh = fdc_pkg::FMT_B;
			2'b11: nxt_st.fmt_oh = fdc_pkg::FMT_C;
		endcase
		nxt_st.int_n = ~|(nxt_st.flags & st_ff.mask & fdc_pkg::INT_EVENT_MASK);
		nxt_st.rdata = (RD_I && ADDR_I == fdc_pkg::ADDR_INT_FLAGS) ? st_ff.flags : 8'h00;
	end

	// State register with synchronous reset and clock enable
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RST_N_I)
		begin
			st_ff           <= '0;
			st_ff.sub_en    <= fdc_pkg::RST_SUB_EN;
			st_ff.main_en   <= fdc_pkg::RST_MAIN_EN;
			st_ff.fmt       <= fdc_pkg::RST_FRAME_FMT;
			st_ff.page      <= fdc_pkg::RST_PAGE_CTRL;
			st_ff.flags     <= fdc_pkg::RST_INT;
			st_ff.int_n     <= 1'b1;
			st_ff.mode      <= mode_of(fdc_pkg::RST_SUB_EN, fdc_pkg::RST_MAIN_EN);
			st_ff.fmt_oh    <= fdc_pkg::FMT_B;
			st_ff.page_last <= last_of(fdc_pkg::RST_PAGE_CTRL[1:0]);
		end
		else if (CE_I)
			st_ff <= nxt_st;
	end

	// Outputs straight from the state register
	assign RDATA_O        = st_ff.rdata;
	assign INT_N_O        = st_ff.int_n;
	assign MODE_O         = st_ff.mode;
	assign FMT_O          = st_ff.fmt_oh;
	assign PAGE_EN_O      = st_ff.page[fdc_pkg::BIT_PAGE_EN];
	assign PKT_ADDR_O     = st_ff.pkt_addr;
	assign PAGE_LAST_O    = st_ff.page_last;
	assign MAIN_RESET_O   = st_ff.page[fdc_pkg::BIT_SOFT_CLEAR];
	assign SYNC_ISOLATE_O = st_ff.iso;
	assign PARITY_ERC2_O  = st_ff.page[fdc_pkg::BIT_PARITY_ERC2];

	// Checks
	property p_mode_reset;
		@(posedge SYS_CLK_I) !RST_N_I |=> MODE_O == fdc_pkg::MODE_MAIN;
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("mode not main after reset");

	property p_mode_write;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && WR_I && ADDR_I == fdc_pkg::ADDR_CHAN_MODE && WDATA_I[4] && WDATA_I[0]
		|=> MODE_O == fdc_pkg::MODE_TIMING;
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("timing mode not entered");

	property p_fmt_reset;
		@(posedge SYS_CLK_I) !RST_N_I |=> FMT_O == fdc_pkg::FMT_B;
	endproperty
	a_fmt_reset: assert property (p_fmt_reset) else $error("format not B after reset");

	property p_event_sets;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && EVENT_I[7] |=> st_ff.flags[7];
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("event lost");

	property p_w1c;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && wr_flags && WDATA_I[5] && !EVENT_I[5] |=> !st_ff.flags[5];
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared");

	property p_soft_clear;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		MAIN_RESET_O && CE_I |=> st_ff.flags[1] == 1'b0 && PKT_ADDR_O == 9'h000;
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("soft clear not holding");

	property p_int_out;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		$past(CE_I) && $stable(st_ff.mask) |-> INT_N_O == ((st_ff.flags & st_ff.mask) == 8'h00);
	endproperty
	a_int_out: assert property (p_int_out) else $error("interrupt not asserted");

	property p_mask_reset;
		@(posedge SYS_CLK_I) !RST_N_I ##1 RST_N_I && !CE_I |-> INT_N_O;
	endproperty
	a_mask_reset: assert property (p_mask_reset) else $error("interrupt after reset");

	property p_restart;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && WR_I && ADDR_I == fdc_pkg::ADDR_PAGE_CTRL && WDATA_I[3] ##1 CE_I |=> PKT_ADDR_O == 9'h000;
	endproperty
	a_restart: assert property (p_restart) else $error("page restart ignored");

	// Mode and format decode straight from a write
	property p_mode_sub;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && WR_I && ADDR_I == fdc_pkg::ADDR_CHAN_MODE && WDATA_I[fdc_pkg::BIT_SUB_EN] && !WDATA_I[fdc_pkg::BIT_MAIN_EN]
		|=> MODE_O == fdc_pkg::MODE_SUB;
	endproperty
	a_mode_sub: assert property (p_mode_sub) else $error("subchannel mode not entered");

	property p_mode_main;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && WR_I && ADDR_I == fdc_pkg::ADDR_CHAN_MODE && !WDATA_I[fdc_pkg::BIT_SUB_EN] && WDATA_I[fdc_pkg::BIT_MAIN_EN]
		|=> MODE_O == fdc_pkg::MODE_MAIN;
	endproperty
	a_mode_main: assert property (p_mode_main) else $error("main mode not entered");

	property p_iso_write;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && WR_I && ADDR_I == fdc_pkg::ADDR_CHAN_MODE && !WDATA_I[fdc_pkg::BIT_SUB_EN] && !WDATA_I[fdc_pkg::BIT_MAIN_EN]
		|=> SYNC_ISOLATE_O;
	endproperty
	a_iso_write: assert property (p_iso_write) else $error("sync circuit not isolated");

	property p_fmt_write;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && WR_I && ADDR_I == fdc_pkg::ADDR_FRAME_FMT && WDATA_I[1:0] == 2'b11
		|=> FMT_O == fdc_pkg::FMT_C;
	endproperty
	a_fmt_write: assert property (p_fmt_write) else $error("format C not selected");

	// Page pointer advances only in page mode and wraps at the area end
	property p_page_idle;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && !PAGE_EN_O && !st_ff.page[fdc_pkg::BIT_PAGE_RESTART] && !MAIN_RESET_O
		|=> $stable(PKT_ADDR_O);
	endproperty
	a_page_idle: assert property (p_page_idle) else $error("pointer moved outside page mode");

	property p_area_wrap;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && PAGE_EN_O && PKT_STORE_I && PKT_ADDR_O == PAGE_LAST_O && !st_ff.page[fdc_pkg::BIT_PAGE_RESTART]
		&& !MAIN_RESET_O |=> PKT_ADDR_O == 9'h000;
	endproperty
	a_area_wrap: assert property (p_area_wrap) else $error("pointer did not wrap");

	// Soft clear spares the subchannel path and the parameter registers
	property p_sub_in_clear;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && MAIN_RESET_O && EVENT_I[fdc_pkg::BIT_SUB_PKT]
		|=> st_ff.flags[fdc_pkg::BIT_SUB_PKT];
	endproperty
	a_sub_in_clear: assert property (p_sub_in_clear) else $error("subchannel event lost in soft clear");

	property p_params_kept;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && MAIN_RESET_O && !WR_I
		|=> $stable(MODE_O) && $stable(FMT_O);
	endproperty
	a_params_kept: assert property (p_params_kept) else $error("parameters changed in soft clear");

	// Live-packet status follows the main packet flag and never interrupts
	property p_live_clear;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CE_I && wr_flags && WDATA_I[fdc_pkg::BIT_MAIN_PKT] && !EVENT_I[fdc_pkg::BIT_MAIN_PKT]
		|=> !st_ff.flags[fdc_pkg::BIT_LIVE_PKT];
	endproperty
	a_live_clear: assert property (p_live_clear) else $error("live status not cleared");

	property p_no_live_int;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		(st_ff.flags & fdc_pkg::INT_EVENT_MASK) == 8'h00
		|-> INT_N_O;
	endproperty
	a_no_live_int: assert property (p_no_live_int) else $error("interrupt without an event flag");

	// Clock enable low leaves every state bit as it was while reset is high
	property p_freeze;
		@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		!CE_I
		|=> $stable(st_ff);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

	c_timing: cover property (@(posedge SYS_CLK_I) MODE_O == fdc_pkg::MODE_TIMING);
	c_int: cover property (@(posedge SYS_CLK_I) !INT_N_O);
	c_page: cover property (@(posedge SYS_CLK_I) PAGE_EN_O && PKT_STORE_I);
	c_clear: cover property (@(posedge SYS_CLK_I) MAIN_RESET_O ##1 !MAIN_RESET_O);
endmodule

//--- design/fdc_pkg.sv
// Package for the FM data demodulator control register group.
// Assumes an 8-bit host bus with 6-bit addresses on the device system clock.
package fdc_pkg;
	// Register offsets
	localparam logic [5:0] ADDR_INT_FLAGS   = 6'h00;
	localparam logic [5:0] ADDR_INT_MASK    = 6'h01;
	localparam logic [5:0] ADDR_CHAN_MODE   = 6'h04;
	localparam logic [5:0] ADDR_FRAME_FMT   = 6'h1f;
	localparam logic [5:0] ADDR_PAGE_CTRL   = 6'h3e;
	// Channel mode field positions and reset
	localparam int         BIT_SUB_EN       = 4;
	localparam int         BIT_MAIN_EN      = 0;
	localparam logic       RST_SUB_EN       = 1'b0;
	localparam logic       RST_MAIN_EN      = 1'b1;
	// Frame format
	localparam logic [1:0] RST_FRAME_FMT    = 2'h2;
	// Page control field positions
	localparam int         BIT_SOFT_CLEAR   = 6;
	localparam int         BIT_PARITY_ERC2  = 4;
	localparam int         BIT_PAGE_RESTART = 3;
	localparam int         BIT_PAGE_EN      = 2;
	localparam logic [6:0] RST_PAGE_CTRL    = 7'h00;
	// Interrupt flag positions
	localparam int         BIT_SUB_PKT      = 7;
	localparam int         BIT_SUB_TIMER    = 6;
	localparam int         BIT_MAIN_TIMER   = 5;
	localparam int         BIT_FRAME_RX     = 4;
	localparam int         BIT_SYNC_LOSS    = 2;
	localparam int         BIT_MAIN_PKT     = 1;
	localparam int         BIT_LIVE_PKT     = 0;
	localparam logic [7:0] INT_EVENT_MASK   = 8'hf6;
	localparam logic [7:0] RST_INT          = 8'h00;
	// Main-path events that soft clear holds off
	localparam logic [7:0] MAIN_PATH_EVENTS = 8'h37;
	// Frame memory size in packets
	localparam logic [8:0] PKT_TOP          = 9'h110;
	// Operating modes
	typedef enum logic [3:0] {
		MODE_OFF    = 4'b0001,
		MODE_MAIN   = 4'b0010,
		MODE_SUB    = 4'b0100,
		MODE_TIMING = 4'b1000
	} fdc_mode_t;
	// Frame formats
	typedef enum logic [3:0] {
		FMT_A0 = 4'b0001,
		FMT_A1 = 4'b0010,
		FMT_B  = 4'b0100,
		FMT_C  = 4'b1000
	} fdc_fmt_t;
endpackage

//--- tb/fdc_host.sv
// Host bus model: the microcontroller side of the 8-bit register port.
// Assumes one clock; every request changes 1 ns after a rising edge.
`timescale 1ns/1ns
module fdc_host
(
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	output logic            ce_o,
	output logic      [5:0] addr_o,
	output logic      [7:0] wdata_o,
	output logic            wr_o,
	output logic            rd_o
);
	// Idle bus: strobes low, address and data parked on unused values
	initial
	begin
		ce_o = 1'b1;
		addr_o = 6'h2a;
		wdata_o = 8'h5a;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// One write, held until the edge that takes it; then the bus is inverted
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i) #1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge clk_i) #1;
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
	// Clock enable level, changed just after an edge
	task automatic en(input logic c);
		@(posedge clk_i) #1;
		ce_o = c;
	endtask
	// One read; the answer stands for the cycle after the taking edge
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_i) #1;
		addr_o = a;
		rd_o = 1'b1;
		@(posedge clk_i) #1;
		rd_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
	endtask
endmodule

//--- tb/tb_fdc_regs.sv
// Self-checking bench of the control and interrupt registers.
// Assumes fdc_pkg, fdc_regs and fdc_host are compiled first.
`timescale 1ns/1ns
module tb_fdc_regs;
	logic       clk = 1'b0, rst_n = 1'b0, live = 1'b0, store = 1'b0;
	logic       ce, wr, rd, iso, par, page_en, main_rst, int_n;
	logic [5:0] addr;
	logic [7:0] wdata, rdata, r, ev = 8'h00;
	logic [3:0] mode, fmt;
	logic [8:0] pkt_addr, page_last;
	int         n_errors = 0, n_checks = 0, cyc = 0;
	logic [7:0] mv[4] = '{8'h11, 8'h01, 8'h10, 8'h00};
	logic [3:0] me[4] = '{4'h8, 4'h2, 4'h4, 4'h1};
	logic [8:0] pl[4] = '{9'h01f, 9'h03f, 9'h07f, 9'h10f};
	int         fb[6] = '{7, 6, 5, 4, 2, 1};
	// Host and design
	fdc_host fdc_host_i (.clk_i(clk), .rdata_i(rdata), .ce_o(ce), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd));
	fdc_regs fdc_regs_i (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .EVENT_I(ev), .LIVE_PKT_I(live), .PKT_STORE_I(store),
		.INT_N_O(int_n), .MODE_O(mode), .FMT_O(fmt), .PAGE_EN_O(page_en), .PKT_ADDR_O(pkt_addr),
		.PAGE_LAST_O(page_last), .MAIN_RESET_O(main_rst), .SYNC_ISOLATE_O(iso), .PARITY_ERC2_O(par));
	// Clock
	always #5 clk = ~clk;
	task automatic conclude();
		if (n_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			conclude();
		end
	end
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One-cycle event pulse, then room for flag and interrupt pin to settle
	task automatic pulse(input logic [7:0] e, input logic l);
		@(posedge clk) #1;
		ev = e;
		live = l;
		@(posedge clk) #1;
		ev = 8'h00;
		live = ~l;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic st(input int n);
		repeat (n)
		begin
			@(posedge clk) #1 store = 1'b1;
			@(posedge clk) #1 store = 1'b0;
		end
		@(posedge clk) #1;
	endtask
	task automatic rdf(input logic [7:0] exp);
		fdc_host_i.rd(6'h00, r);
		chk(9'(r), 9'(exp));
	endtask
	task automatic clr(input logic [7:0] v);
		fdc_host_i.wr(6'h00, v);
		@(posedge clk) #1;
	endtask
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		chk(9'(mode), 9'h002);
		chk(9'(fmt), 9'h004);
		chk(9'(int_n), 9'h001);
		for (int i = 0; i < 4; i++)
		begin
			fdc_host_i.wr(6'h04, mv[i]);
			chk(9'(mode), 9'(me[i]));
			chk(9'(iso), 9'(i == 3));
			fdc_host_i.wr(6'h1f, 8'(i));
			chk(9'(fmt), 9'(4'h1 << i));
		end
		fdc_host_i.wr(6'h04, 8'h10);
		for (int i = 0; i < 4; i++)
		begin
			fdc_host_i.wr(6'h3e, 8'(20 + i));
			@(posedge clk) #1;
			chk(page_last, pl[i]);
		end
		chk(9'({page_en, par}), 9'h003);
		fdc_host_i.wr(6'h3e, 8'h04);
		st(3);
		chk(pkt_addr, 9'h003);
		fdc_host_i.wr(6'h3e, 8'h0c);
		st(0);
		chk(pkt_addr, 9'h000);
		st(32);
		chk(pkt_addr, 9'h000);
		fdc_host_i.wr(6'h3e, 8'h00);
		fdc_host_i.wr(6'h04, 8'h01);
		pulse(8'h80, 1'b0);
		chk(9'(int_n), 9'h001);
		rdf(8'h80);
		clr(8'h80);
		fdc_host_i.wr(6'h01, 8'hf6);
		for (int i = 0; i < 6; i++)
		begin
			pulse(8'h01 << fb[i], 1'b0);
			chk(9'(int_n), 9'h000);
			rdf(8'h01 << fb[i]);
			clr(~(8'h01 << fb[i]));
			rdf(8'h01 << fb[i]);
			clr(8'h01 << fb[i]);
			chk(9'(int_n), 9'h001);
		end
		pulse(8'h03, 1'b1);
		rdf(8'h03);
		clr(8'h02);
		rdf(8'h00);
		pulse(8'h84, 1'b0);
		clr(8'h80);
		chk(9'(int_n), 9'h000);
		clr(8'h04);
		chk(9'(int_n), 9'h001);
		pulse(8'h82, 1'b0);
		fdc_host_i.wr(6'h3e, 8'h40);
		chk(9'(main_rst), 9'h001);
		pulse(8'h02, 1'b0);
		rdf(8'h80);
		fdc_host_i.wr(6'h3e, 8'h00);
		chk(9'({main_rst, mode}), 9'h002);
		pulse(8'h02, 1'b0);
		rdf(8'h82);
		fdc_host_i.wr(6'h3f, 8'h10);
		chk(9'(mode), 9'h002);
		fdc_host_i.rd(6'h04, r);
		chk(9'(r), 9'h000);
		// Mid-run reset with the clock enable low: reset values, then a frozen event
		fdc_host_i.wr(6'h04, 8'h11);
		fdc_host_i.wr(6'h1f, 8'h03);
		fdc_host_i.wr(6'h01, 8'h80);
		pulse(8'h80, 1'b0);
		chk(9'({int_n, mode}), 9'h008);
		fdc_host_i.en(1'b0);
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		pulse(8'h80, 1'b0);
		chk(9'({int_n, mode, fmt}), 9'h124);
		fdc_host_i.en(1'b1);
		rdf(8'h00);
		conclude();
	end
endmodule
